/* ips_defines.svh */
/*
 * Constants of the i/o and user-variable command block: frame layout,
 * instruction and bank codes, status codes, port counts and reset values.
 * Assumes it is included by name wherever a constant is used.
 */
`ifndef IPS_DEFINES_SVH
`define IPS_DEFINES_SVH

// ***************************************************
// frame and addressing
// ***************************************************
`define IPS_MOD_ADDR 8'h01
`define IPS_HOST_ADDR 8'h02
`define IPS_CHK_POS 4'h8

// ***************************************************
// instruction and bank codes
// ***************************************************
`define IPS_INS_STORE 8'h0b
`define IPS_INS_RESTORE 8'h0c
`define IPS_INS_SETOUT 8'h0e
`define IPS_INS_READ 8'h0f
`define IPS_BANK_DIN 8'h00
`define IPS_BANK_AIN 8'h01
`define IPS_BANK_OUT 8'h02
`define IPS_BANK_UVAR 8'h02

// ***************************************************
// reply status codes
// ***************************************************
`define IPS_ST_OK 8'h64
`define IPS_ST_BAD_CHK 8'h01
`define IPS_ST_BAD_CMD 8'h02
`define IPS_ST_BAD_TYPE 8'h03
`define IPS_ST_BAD_VAL 8'h04

// ***************************************************
// port counts, widths, reset values
// ***************************************************
`define IPS_NUM_DIN 8'h04
`define IPS_NUM_AIN 8'h04
`define IPS_AIN_TEMP 8'h03
`define IPS_AIN_W 12
`define IPS_NUM_GPO 8'h02
`define IPS_GPO_RST 2'h0
`define IPS_NUM_UVAR 8'h10
`define IPS_UVAR_IW 4

`endif

/* ips_pkg.sv */
/*
 * Types shared by the command block: frame layout, states and the
 * packed state records of each module.
 * Assumes ips_defines.svh is on the include path.
 */
`default_nettype none
`include "ips_defines.svh"

package ips_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] ins;
      logic [7:0] typ;
      logic [7:0] bank;
      logic [31:0] val;
   } ips_frame_t;

   typedef enum logic {IPS_OP_STORE, IPS_OP_RESTORE} ips_nv_op_t;
   typedef enum logic [2:0] {S_BOOT, S_RX, S_EXEC, S_NV, S_DRAIN} ips_state_t;
   typedef enum logic {U_LOAD, U_IDLE} ips_ustate_t;
   typedef logic [`IPS_NUM_UVAR-1:0][31:0] ips_uarr_t;

   typedef struct packed {
      ips_state_t state;
      logic rdy;
      logic [3:0] cnt;
      logic [7:0] sum;
      logic [7:0][7:0] fbytes;
      logic chk_ok;
      logic sa;
      logic [7:0] status;
      logic [31:0] rval;
      logic [1:0] gpo;
      logic [31:0] acc;
      logic acc_load;
      logic tx_start;
      logic req;
      ips_nv_op_t op;
      logic [`IPS_UVAR_IW-1:0] idx;
      logic [31:0] rd_data;
   } ips_top_st_t;

   typedef struct packed {
      ips_ustate_t st;
      logic rdy;
      logic [`IPS_UVAR_IW-1:0] cnt;
      logic done;
      ips_uarr_t uvar;
      ips_uarr_t nv;
   } ips_uv_st_t;

   typedef struct packed {
      logic busy;
      logic vld;
      logic [3:0] cnt;
      logic [7:0] sum;
      logic [7:0][7:0] sh;
      logic [7:0] tbyte;
   } ips_tx_st_t;
endpackage

`default_nettype wire

/* ips_if.sv */
/*
 * Carriers between the command core and its two helpers: the user
 * variable store and the reply serialiser.
 * Assumes ips_pkg is compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ips_defines.svh"

interface ips_uv_if;
   logic req;
   ips_pkg::ips_nv_op_t op;
   logic [`IPS_UVAR_IW-1:0] idx;
   logic done;
   logic ready;
   logic wr_en;
   logic [`IPS_UVAR_IW-1:0] wr_idx;
   logic [31:0] wr_data;
   logic [`IPS_UVAR_IW-1:0] rd_idx;
   logic [31:0] rd_data;
   modport ctl (output req, op, idx, wr_en, wr_idx, wr_data, rd_idx,
                input done, ready, rd_data);
   modport mem (input req, op, idx, wr_en, wr_idx, wr_data, rd_idx,
                output done, ready, rd_data);
endinterface

interface ips_tx_if;
   logic start;
   logic [7:0] status;
   logic [7:0] ins;
   logic [31:0] val;
   logic busy;
   modport src (output start, status, ins, val, input busy);
   modport tx (input start, status, ins, val, output busy);
endinterface

`default_nettype wire

/* ips_uvar_store.sv */
/*
 * User variables with their non-volatile copy: whole reload after reset,
 * single store and restore on request, plus a plain write and read port.
 * Assumes requests come only while ready is high.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ips_defines.svh"

module ips_uvar_store (
   input wire logic clk,
   input wire logic rst_b,
   ips_uv_if.mem uv
);
   ips_pkg::ips_uv_st_t q;
   ips_pkg::ips_uv_st_t d;
   logic [31:0] sel_uvar;
   logic [31:0] sel_nv;

   // next state; nv copy deliberately escapes reset, it stands for eeprom
   always_comb
   begin
      d = q;
      d.done = 1'b0;
      case (q.st)
         ips_pkg::U_LOAD:
         begin
            d.uvar[q.cnt] = q.nv[q.cnt];
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == `IPS_NUM_UVAR - 8'h01)
            begin
               d.st = ips_pkg::U_IDLE;
               d.rdy = 1'b1;
            end
         end
         ips_pkg::U_IDLE:
         begin
            if (uv.wr_en)
               d.uvar[uv.wr_idx] = uv.wr_data;
            // a restore wins over a plain write to the same entry; a store saves the entry as it was before the write
            if (uv.req)
            begin
               if (uv.op == ips_pkg::IPS_OP_RESTORE)
                  d.uvar[uv.idx] = q.nv[uv.idx];
               else
                  d.nv[uv.idx] = q.uvar[uv.idx];
               d.done = 1'b1;
            end
         end
         default: d.st = ips_pkg::U_LOAD;
      endcase
      if (!rst_b)
      begin
         d = '0;
         d.nv = q.nv;
         d.st = ips_pkg::U_LOAD;
      end
   end

   always_ff @(posedge clk)
      q <= d;

   assign uv.rd_data = q.uvar[uv.rd_idx];
   assign uv.ready = q.rdy;
   assign uv.done = q.done;
   assign sel_uvar = q.uvar[uv.idx];
   assign sel_nv = q.nv[uv.idx];

   a_store_copy:
      assert property (@(posedge clk) disable iff (!rst_b)
         (uv.req && q.rdy && uv.op == ips_pkg::IPS_OP_STORE)
         |=> uv.done && q.nv[$past(uv.idx)] == $past(sel_uvar))
      else $error("store did not copy the variable");

   a_restore_copy:
      assert property (@(posedge clk) disable iff (!rst_b)
         (uv.req && q.rdy && uv.op == ips_pkg::IPS_OP_RESTORE)
         |=> uv.done && q.uvar[$past(uv.idx)] == $past(sel_nv))
      else $error("restore did not reload the variable");

   a_boot_time:
      assert property (@(posedge clk) $rose(rst_b) |-> ##16 q.rdy)
      else $error("reload not finished in sixteen cycles");
endmodule

`default_nettype wire

/* ips_reply_tx.sv */
/*
 * Reply serialiser: nine bytes, most significant value byte first,
 * closed by the modulo-256 sum of the eight bytes before it.
 * Assumes start is a pulse given only while busy is low.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ips_defines.svh"

module ips_reply_tx (
   input wire logic clk,
   input wire logic rst_b,
   ips_tx_if.tx tx,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready
);
   ips_pkg::ips_tx_st_t q;
   ips_pkg::ips_tx_st_t d;

   // load the frame, then shift one byte out per handshake
   always_comb
   begin
      d = q;
      if (!q.busy)
      begin
         if (tx.start)
         begin
            d.sh = {`IPS_HOST_ADDR, `IPS_MOD_ADDR, tx.status, tx.ins, tx.val};
            d.busy = 1'b1;
            d.vld = 1'b1;
            d.tbyte = `IPS_HOST_ADDR;
            d.sum = `IPS_HOST_ADDR;
            d.cnt = 4'h0;
         end
      end
      else if (q.vld && tx_ready)
      begin
         d.cnt = q.cnt + 4'h1;
         d.sh = {q.sh[6:0], 8'h00};
         if (q.cnt == `IPS_CHK_POS)
         begin
            d.busy = 1'b0;
            d.vld = 1'b0;
         end
         else if (q.cnt == `IPS_CHK_POS - 4'h1)
            d.tbyte = q.sum;
         else
         begin
            d.tbyte = q.sh[6];
            d.sum = q.sum + q.sh[6]; // wraps, hence modulo 256
         end
      end
      if (!rst_b)
         d = '0;
   end

   always_ff @(posedge clk)
      q <= d;

   assign tx_valid = q.vld;
   assign tx_byte = q.tbyte;
   assign tx.busy = q.busy;

   a_reply_head:
      assert property (@(posedge clk) disable iff (!rst_b)
         (tx.start && !q.busy) |=> tx_valid && tx_byte == `IPS_HOST_ADDR && q.cnt == 4'h0)
      else $error("reply does not open with the host address");

   a_reply_second:
      assert property (@(posedge clk) disable iff (!rst_b)
         (tx_valid && tx_ready && q.cnt == 4'h0) |=> tx_valid && tx_byte == `IPS_MOD_ADDR)
      else $error("module address does not follow the host address");

   a_reply_end:
      assert property (@(posedge clk) disable iff (!rst_b)
         (tx_valid && tx_ready && q.cnt == `IPS_CHK_POS) |=> !tx_valid && !tx.busy)
      else $error("reply longer than nine bytes");
endmodule

`default_nettype wire

/* ips_cmd_top.sv */
/*
 * Command core for the user-variable store and restore, output set and
 * port read instructions: frame intake, checksum check, dispatch, reply.
 * Assumes a byte stream with valid/ready on both sides, synchronous
 * inputs, and a standalone level that is high while a program runs.
 */
// Behaviour
// - code 11 bank 2 saves variable
// - code 12 bank 2 reloads saved variable
// - all variables reload after reset first
// - store, restore, set reply ok
// - code 14 drives selected output level
// - code 15 reads port by type, bank
// - digital 0/1, analog twelve bit unsigned
// - program mode loads read into accumulator
// - direct mode leaves accumulator untouched
// - output states readable through port read
// - port read replies ok with value
// - reply order fixed, ok is 64 hex
// - bank 0 gives digital inputs 0-3
// - bank 1 analog 0-3, temperature 16 bit
// - bank 2 holds the user variables
`timescale 1ns/1ns
`default_nettype none
`include "ips_defines.svh"

module ips_cmd_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic standalone,
   input wire logic [`IPS_NUM_DIN-1:0] din,
   input wire logic [`IPS_NUM_AIN-1:0][15:0] ain,
   output logic [`IPS_NUM_GPO-1:0] gpo,
   output logic [31:0] acc,
   output logic acc_load,
   output logic boot_done,
   input wire logic uvar_wr_en,
   input wire logic [`IPS_UVAR_IW-1:0] uvar_wr_idx,
   input wire logic [31:0] uvar_wr_data,
   input wire logic [`IPS_UVAR_IW-1:0] uvar_rd_idx,
   output logic [31:0] uvar_rd_data
);
   ips_pkg::ips_top_st_t q;
   ips_pkg::ips_top_st_t d;
   ips_pkg::ips_frame_t fr;
   logic [`IPS_NUM_AIN-1:0][31:0] ain_val;
   logic [31:0] port_val;
   logic port_ok;
   logic cmd_go;
   logic sio_hit;
   logic fr_sel;
   logic fr_bit;

   ips_uv_if uv();
   ips_tx_if tx();

   // ***************************************************
   // helpers
   // ***************************************************
   ips_uvar_store u_store (
      .clk(clk),
      .rst_b(rst_b),
      .uv(uv.mem)
   );

   ips_reply_tx u_tx (
      .clk(clk),
      .rst_b(rst_b),
      .tx(tx.tx),
      .tx_valid(tx_valid),
      .tx_byte(tx_byte),
      .tx_ready(tx_ready)
   );

   // frame bytes are held until the next frame, so tx may read them late
   assign fr = ips_pkg::ips_frame_t'(q.fbytes);
   assign uv.req = q.req;
   assign uv.op = q.op;
   assign uv.idx = q.idx;
   assign uv.wr_en = uvar_wr_en;
   assign uv.wr_idx = uvar_wr_idx;
   assign uv.wr_data = uvar_wr_data;
   assign uv.rd_idx = uvar_rd_idx;
   assign tx.start = q.tx_start;
   assign tx.status = q.status;
   assign tx.ins = fr.ins;
   assign tx.val = q.rval;

   // ***************************************************
   // port read selection
   // ***************************************************
   // converters give 12 bits; the temperature channel keeps all 16
   genvar gi;
   generate
      for (gi = 0; gi < `IPS_NUM_AIN; gi++)
      begin : g_ain
         assign ain_val[gi] = (gi == `IPS_AIN_TEMP) ? {16'h0000, ain[gi]} :
                              {20'h00000, ain[gi][`IPS_AIN_W-1:0]};
      end
   endgenerate

   // value and validity of the port named by type and bank
   always_comb
   begin
      port_val = 32'h0000_0000;
      port_ok = 1'b0;
      case (fr.bank)
         `IPS_BANK_DIN:
         begin
            port_ok = (fr.typ < `IPS_NUM_DIN);
            port_val = {31'h0000_0000, din[fr.typ[1:0]]};
         end
         `IPS_BANK_AIN:
         begin
            port_ok = (fr.typ < `IPS_NUM_AIN);
            port_val = ain_val[fr.typ[1:0]];
         end
         `IPS_BANK_OUT:
         begin
            port_ok = (fr.typ < `IPS_NUM_GPO);
            port_val = {31'h0000_0000, q.gpo[fr.typ[0]]};
         end
         default: port_ok = 1'b0;
      endcase
   end

   // ***************************************************
   // command sequencer
   // ***************************************************
   // one frame at a time: intake stalls until the reply has left
   always_comb
   begin
      d = q;
      d.acc_load = 1'b0;
      d.tx_start = 1'b0;
      d.req = 1'b0;
      d.rd_data = uv.rd_data;
      case (q.state)
         ips_pkg::S_BOOT:
         begin
            if (uv.ready)
               d.state = ips_pkg::S_RX;
         end
         ips_pkg::S_RX:
         begin
            if (rx_valid && q.rdy)
            begin
               if (q.cnt == `IPS_CHK_POS)
               begin
                  d.chk_ok = (rx_byte == q.sum);
                  d.sa = standalone;
                  d.cnt = 4'h0;
                  d.sum = 8'h00;
                  d.state = ips_pkg::S_EXEC;
               end
               else
               begin
                  d.fbytes = {q.fbytes[6:0], rx_byte};
                  d.sum = q.sum + rx_byte;
                  d.cnt = q.cnt + 4'h1;
               end
            end
         end
         ips_pkg::S_EXEC:
         begin
            d.status = `IPS_ST_OK;
            d.rval = 32'h0000_0000;
            d.state = ips_pkg::S_DRAIN;
            d.tx_start = !q.sa;
            if (fr.addr != `IPS_MOD_ADDR)
               d.tx_start = 1'b0;
            else if (!q.chk_ok)
               d.status = `IPS_ST_BAD_CHK;
            else
            begin
               case (fr.ins)
                  `IPS_INS_STORE, `IPS_INS_RESTORE:
                  begin
                     if (fr.bank != `IPS_BANK_UVAR || fr.typ >= `IPS_NUM_UVAR)
                        d.status = `IPS_ST_BAD_TYPE;
                     else
                     begin
                        d.req = 1'b1;
                        d.op = (fr.ins == `IPS_INS_RESTORE) ? ips_pkg::IPS_OP_RESTORE :
                               ips_pkg::IPS_OP_STORE;
                        d.idx = fr.typ[`IPS_UVAR_IW-1:0];
                        d.tx_start = 1'b0;
                        d.state = ips_pkg::S_NV;
                     end
                  end
                  `IPS_INS_SETOUT:
                  begin
                     if (fr.bank != `IPS_BANK_OUT || fr.typ >= `IPS_NUM_GPO)
                        d.status = `IPS_ST_BAD_TYPE;
                     else if (fr.val > 32'h0000_0001)
                        d.status = `IPS_ST_BAD_VAL;
                     else
                        d.gpo[fr.typ[0]] = fr.val[0];
                  end
                  `IPS_INS_READ:
                  begin
                     if (!port_ok)
                        d.status = `IPS_ST_BAD_TYPE;
                     else
                     begin
                        d.rval = port_val;
                        if (q.sa)
                        begin
                           d.acc = port_val;
                           d.acc_load = 1'b1;
                        end
                     end
                  end
                  default: d.status = `IPS_ST_BAD_CMD;
               endcase
            end
         end
         ips_pkg::S_NV:
         begin
            if (uv.done)
            begin
               d.tx_start = !q.sa;
               d.state = ips_pkg::S_DRAIN;
            end
         end
         ips_pkg::S_DRAIN:
         begin
            // busy rises one cycle after start, hence the start term
            if (!tx.busy && !q.tx_start)
               d.state = ips_pkg::S_RX;
         end
         default: d.state = ips_pkg::S_RX;
      endcase
      d.rdy = (d.state == ips_pkg::S_RX);
      if (!rst_b)
      begin
         d = '0;
         d.gpo = `IPS_GPO_RST;
         d.state = ips_pkg::S_BOOT;
      end
   end

   always_ff @(posedge clk)
      q <= d;

   assign rx_ready = q.rdy;
   assign gpo = q.gpo;
   assign acc = q.acc;
   assign acc_load = q.acc_load;
   assign boot_done = uv.ready;
   assign uvar_rd_data = q.rd_data;

   // ***************************************************
   // checks
   // ***************************************************
   assign cmd_go = (q.state == ips_pkg::S_EXEC) && q.chk_ok && (fr.addr == `IPS_MOD_ADDR);
   assign sio_hit = cmd_go && fr.ins == `IPS_INS_SETOUT && fr.bank == `IPS_BANK_OUT &&
                    fr.typ < `IPS_NUM_GPO && fr.val <= 32'h0000_0001;
   assign fr_sel = fr.typ[0];
   assign fr_bit = fr.val[0];

   a_boot_gate:
      assert property (@(posedge clk) disable iff (!rst_b) !uv.ready |-> !q.rdy)
      else $error("frame intake open before reload");

   a_sio_drive:
      assert property (@(posedge clk) disable iff (!rst_b)
         sio_hit |=> gpo[$past(fr_sel)] == $past(fr_bit))
      else $error("output not driven to commanded level");

   a_gpo_hold:
      assert property (@(posedge clk) disable iff (!rst_b) !sio_hit |=> $stable(gpo))
      else $error("output changed without a valid set command");

   a_acc_direct:
      assert property (@(posedge clk) disable iff (!rst_b)
         (cmd_go && !q.sa) |=> $stable(acc) && !acc_load)
      else $error("direct command touched the accumulator");

   a_acc_prog:
      assert property (@(posedge clk) disable iff (!rst_b)
         (cmd_go && q.sa && fr.ins == `IPS_INS_READ && port_ok)
         |=> acc_load && acc == $past(port_val) ##1 !acc_load)
      else $error("program read not loaded into accumulator");

   a_read_reply:
      assert property (@(posedge clk) disable iff (!rst_b)
         (cmd_go && !q.sa && fr.ins == `IPS_INS_READ && port_ok)
         |=> tx.start && tx.status == `IPS_ST_OK && tx.val == $past(port_val))
      else $error("port read reply wrong");

   a_nv_reply:
      assert property (@(posedge clk) disable iff (!rst_b)
         (q.state == ips_pkg::S_NV && uv.done && !q.sa)
         |=> tx.start && tx.status == `IPS_ST_OK)
      else $error("store or restore reply missing");

   a_bad_chk:
      assert property (@(posedge clk) disable iff (!rst_b)
         (q.state == ips_pkg::S_EXEC && !q.chk_ok && fr.addr == `IPS_MOD_ADDR)
         |=> !uv.req && $stable(gpo) && tx.status == `IPS_ST_BAD_CHK)
      else $error("bad checksum frame was acted on");

   a_ain_range:
      assert property (@(posedge clk) disable iff (!rst_b)
         (fr.bank == `IPS_BANK_AIN && fr.typ < `IPS_AIN_TEMP) |-> port_val[31:12] == 20'h00000)
      else $error("converter result wider than twelve bits");

   a_temp_full:
      assert property (@(posedge clk) disable iff (!rst_b)
         (fr.bank == `IPS_BANK_AIN && fr.typ == `IPS_AIN_TEMP) |-> port_val[15:0] == ain[3])
      else $error("temperature channel truncated");

   a_din_read:
      assert property (@(posedge clk) disable iff (!rst_b)
         (fr.bank == `IPS_BANK_DIN && fr.typ == 8'h02) |-> port_val == {31'h0, din[2]})
      else $error("digital input read wrong");

   a_gpo_back:
      assert property (@(posedge clk) disable iff (!rst_b)
         (fr.bank == `IPS_BANK_OUT && fr.typ == 8'h01) |-> port_val[0] == gpo[1] && port_ok)
      else $error("output readback wrong");
endmodule

`default_nettype wire

/* ips_host.sv */
/*
 * host model: sends command frames and collects reply frames.
 * assumes valid/ready byte streams sampled on the rising clk edge.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ips_defines.svh"

module ips_host (
   input wire logic clk,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready
);
   logic slow = 1'b0;

   // idle lines at time zero
   initial
   begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b0;
   end

   // nine bytes, value msb first, sum last; bad corrupts the sum
   task automatic send(input logic [7:0] ins, typ, bank, input logic [31:0] val,
                       input bit bad);
      logic [7:0] f [9];
      f = '{`IPS_MOD_ADDR, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      for (int i = 0; i < 8; i++)
         f[8] += f[i];
      if (bad)
         f[8] = ~f[8];
      for (int i = 0; i < 9; i++)
      begin
         rx_valid = 1'b1;
         rx_byte = f[i];
         for (int w = 0; w < 200 && rx_ready !== 1'b1; w++)
            @(posedge clk) #1;
         @(posedge clk) #1;
      end
      rx_valid = 1'b0;
      rx_byte = ~f[8]; // released line must not look like the last byte
   endtask

   // slow mode holds ready low one cycle per byte to stall the reply
   task automatic recv(output logic [7:0] r [9]);
      for (int i = 0; i < 9; i++)
      begin
         r[i] = 8'hxx;
         tx_ready = !slow;
         for (int w = 0; w < 200 && !(tx_valid === 1'b1 && tx_ready); w++)
         begin
            @(posedge clk) #1;
            tx_ready = 1'b1;
         end
         if (tx_valid === 1'b1)
            r[i] = tx_byte;
         @(posedge clk) #1;
      end
      tx_ready = 1'b0;
   endtask
endmodule

`default_nettype wire

/* tb.sv */
/*
 * self-checking bench for the command core with a host model.
 * assumes the core's constants from ips_defines.svh.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ips_defines.svh"

module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic rx_valid, rx_ready, tx_valid, tx_ready, standalone, acc_load, boot_done;
   logic uvar_wr_en;
   logic [7:0] rx_byte, tx_byte;
   logic [3:0] din, uvar_wr_idx, uvar_rd_idx;
   logic [3:0][15:0] ain;
   logic [1:0] gpo;
   logic [31:0] acc, uvar_wr_data, uvar_rd_data;
   logic [7:0] r [9];
   int n_mismatch = 0;
   int total_checks = 0;

   always #10 clk = ~clk;

   ips_cmd_top u_ips_cmd_top (.clk(clk), .rst_b(rst_b), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_ready(tx_ready), .standalone(standalone), .din(din), .ain(ain), .gpo(gpo),
      .acc(acc), .acc_load(acc_load), .boot_done(boot_done), .uvar_wr_en(uvar_wr_en),
      .uvar_wr_idx(uvar_wr_idx), .uvar_wr_data(uvar_wr_data),
      .uvar_rd_idx(uvar_rd_idx), .uvar_rd_data(uvar_rd_data));

   ips_host u_host (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

   // ****************
   // shared tasks
   // ****************
   task automatic chk(input logic [63:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one direct command; echo and value only judged on success
   task automatic cmd(input logic [7:0] ins, typ, bank, input logic [31:0] val,
                      input logic [7:0] st, input logic [31:0] ev, input bit bad = 0);
      logic [7:0] s;
      u_host.send(ins, typ, bank, val, bad);
      u_host.recv(r);
      s = 8'h00;
      for (int i = 0; i < 8; i++)
         s += r[i];
      chk({r[0], r[1], r[2]}, {`IPS_HOST_ADDR, `IPS_MOD_ADDR, st});
      chk(r[8], s);
      if (st === `IPS_ST_OK)
         chk({r[3], r[4], r[5], r[6], r[7]}, {ins, ev});
   endtask

   // ****************
   // scenarios
   // ****************
   // reset, then wait for the reload to finish under a bound
   task automatic t_reset;
      rst_b = 1'b0;
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      for (int w = 0; w < 40 && boot_done !== 1'b1; w++)
         @(posedge clk) #1;
      @(posedge clk) #1;
      chk({boot_done, gpo, acc}, {1'b1, 2'b00, 32'h0});
   endtask

   task automatic t_out;
      cmd(`IPS_INS_SETOUT, 8'h00, `IPS_BANK_OUT, 32'h1, `IPS_ST_OK, 32'h0);
      chk(gpo, 2'b01);
      cmd(`IPS_INS_SETOUT, 8'h01, `IPS_BANK_OUT, 32'h1, `IPS_ST_OK, 32'h0);
      chk(gpo, 2'b11);
      cmd(`IPS_INS_SETOUT, 8'h00, `IPS_BANK_OUT, 32'h0, `IPS_ST_OK, 32'h0);
      chk(gpo, 2'b10);
      cmd(`IPS_INS_READ, 8'h01, `IPS_BANK_OUT, 32'h0, `IPS_ST_OK, 32'h1);
      cmd(`IPS_INS_READ, 8'h00, `IPS_BANK_OUT, 32'h0, `IPS_ST_OK, 32'h0);
      cmd(`IPS_INS_SETOUT, 8'h02, `IPS_BANK_OUT, 32'h1, `IPS_ST_BAD_TYPE, 32'h0);
      cmd(`IPS_INS_SETOUT, 8'h00, `IPS_BANK_OUT, 32'h2, `IPS_ST_BAD_VAL, 32'h0);
      cmd(`IPS_INS_SETOUT, 8'h00, `IPS_BANK_OUT, 32'h1, `IPS_ST_BAD_CHK, 32'h0, 1);
      cmd(8'h13, 8'h00, 8'h00, 32'h0, `IPS_ST_BAD_CMD, 32'h0);
      cmd(`IPS_INS_READ, 8'h00, 8'h03, 32'h0, `IPS_ST_BAD_TYPE, 32'h0);
      cmd(`IPS_INS_STORE, 8'h00, `IPS_BANK_DIN, 32'h0, `IPS_ST_BAD_TYPE, 32'h0);
      chk(gpo, 2'b10);
   endtask

   // every digital and analog port, reply stalled by the host
   task automatic t_read;
      u_host.slow = 1'b1;
      for (int p = 0; p < 4; p++)
      begin
         cmd(`IPS_INS_READ, p[7:0], `IPS_BANK_DIN, 32'h0, `IPS_ST_OK, {31'h0, din[p]});
         cmd(`IPS_INS_READ, p[7:0], `IPS_BANK_AIN, 32'h0, `IPS_ST_OK,
             p == 3 ? {16'h0, ain[3]} : {20'h0, ain[p][11:0]});
      end
      u_host.slow = 1'b0;
   endtask

   task automatic t_acc;
      standalone = 1'b1;
      u_host.send(`IPS_INS_READ, 8'h03, `IPS_BANK_AIN, 32'h0, 0);
      for (int w = 0; w < 20 && acc_load !== 1'b1; w++)
         @(posedge clk) #1;
      chk({acc_load, acc}, {1'b1, 32'hfffe});
      // a program read must never start a reply
      repeat (3) @(posedge clk) #1;
      chk(tx_valid, 1'b0);
      standalone = 1'b0;
      cmd(`IPS_INS_READ, 8'h01, `IPS_BANK_DIN, 32'h0, `IPS_ST_OK, 32'h1);
      chk(acc, 32'hfffe);
   endtask

   // top index stored, overwritten, restored, then reloaded by reset
   task automatic t_uvar;
      uvar_wr_idx = 4'hf;
      uvar_rd_idx = 4'hf;
      uvar_wr_data = 32'h1234_5678;
      uvar_wr_en = 1'b1;
      @(posedge clk) #1 uvar_wr_en = 1'b0;
      cmd(`IPS_INS_STORE, 8'h0f, `IPS_BANK_UVAR, 32'h0, `IPS_ST_OK, 32'h0);
      uvar_wr_data = 32'hdead_beef;
      uvar_wr_en = 1'b1;
      @(posedge clk) #1 uvar_wr_en = 1'b0;
      @(posedge clk) #1 chk(uvar_rd_data, 32'hdead_beef);
      cmd(`IPS_INS_RESTORE, 8'h0f, `IPS_BANK_UVAR, 32'h0, `IPS_ST_OK, 32'h0);
      chk(uvar_rd_data, 32'h1234_5678);
      cmd(`IPS_INS_STORE, 8'h10, `IPS_BANK_UVAR, 32'h0, `IPS_ST_BAD_TYPE, 32'h0);
      uvar_wr_en = 1'b1;
      @(posedge clk) #1 uvar_wr_en = 1'b0;
      t_reset;
      chk(uvar_rd_data, 32'h1234_5678);
   endtask

   // main sequence
   initial
   begin
      standalone = 1'b0;
      uvar_wr_en = 1'b0;
      uvar_wr_idx = 4'h0;
      uvar_rd_idx = 4'h0;
      uvar_wr_data = 32'h0;
      din = 4'b1010;
      ain = {16'hfffe, 16'h0fff, 16'h0800, 16'hf12c};
      t_reset;
      t_out;
      t_read;
      t_acc;
      t_uvar;
      conclude;
   end

   // watchdog, far beyond the expected run of about 650 cycles
   initial
   begin
      #400000;
      n_mismatch++;
      conclude;
   end
endmodule

`default_nettype wire
